// ### hw/auto_power_mode_scheduler.sv
// Time and event driven scan mode scheduler
`timescale 1ns/100ps
module auto_power_mode_scheduler #(
  parameter int MS_CYCLES = power_mode_pkg::MS_TICK_CYCLES,
  parameter int CHANNELS = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [CHANNELS-1:0] chan_enable,
  input wire logic [CHANNELS-1:0] chan_event,
  output power_mode_pkg::conv_req_t conv_req,
  output logic [1:0] scan_mode
);
  // The masks below are built for eight channels only
  if (CHANNELS != 8 || MS_CYCLES < 2) begin : g_param_check
    $error("auto_power_mode_scheduler: unsupported parameters");
  end

  logic [15:0] gen_settings_ff;
  logic [15:0] report_rates_ff;
  logic [15:0] mode_timer_ff;
  logic [15:0] reg_rdata_ff;
  power_mode_pkg::scan_state_t state_ff;
  power_mode_pkg::scan_state_t nxt_state;
  power_mode_pkg::conv_req_t conv_ff;
  power_mode_pkg::conv_req_t nxt_conv;
  logic [31:0] tick_cnt_ff;
  logic [16:0] quiet_cnt_ff;
  logic [7:0] rate_cnt_ff;
  logic [2:0] min_cnt_ff;

  // Register access at the mapped offsets
  wire wr_gen = reg_wr && reg_addr == power_mode_pkg::GEN_SETTINGS_OFS;
  wire wr_rate = reg_wr && reg_addr == power_mode_pkg::REPORT_RATES_OFS;
  wire wr_timer = reg_wr && reg_addr == power_mode_pkg::MODE_TIMER_OFS;
  wire auto_en = gen_settings_ff[power_mode_pkg::AUTO_EN_BIT];
  wire min_en = gen_settings_ff[power_mode_pkg::MIN_EN_BIT];
  wire [2:0] min_div_field =
    gen_settings_ff[power_mode_pkg::MIN_DIV_LSB +: power_mode_pkg::MIN_DIV_W];
  wire [7:0] timer_field = mode_timer_ff[power_mode_pkg::TIMER_FIELD_LSB +: 8];
  wire [16:0] quiet_limit = 17'(timer_field) * 17'(power_mode_pkg::TIMER_UNIT_MS);
  wire [15:0] gen_rd = {gen_settings_ff[15:10], state_ff, gen_settings_ff[7:0]};
  wire [15:0] rd_mux =
    reg_addr == power_mode_pkg::GEN_SETTINGS_OFS ? gen_rd :
    reg_addr == power_mode_pkg::REPORT_RATES_OFS ? report_rates_ff :
    reg_addr == power_mode_pkg::MODE_TIMER_OFS ? mode_timer_ff : 16'h0000;

  // Millisecond timebase
  wire ms_tick = tick_cnt_ff == 32'(MS_CYCLES - 1);
  wire any_event = |(chan_event & chan_enable);
  // A zero timer field never steps down, so a cleared field holds the current scan mode
  wire quiet_done = timer_field != 8'h00 && quiet_cnt_ff >= quiet_limit;

  // Interval in ms, zero treated as one so scanning never stops
  wire [7:0] rate_sel = state_ff == power_mode_pkg::FULL_RATE_SCAN_STATE ?
    report_rates_ff[7:0] : report_rates_ff[15:8];
  wire [7:0] interval = rate_sel == 8'h00 ? 8'h01 : rate_sel;
  wire rate_due = ms_tick && (rate_cnt_ff + 8'h01) >= interval;
  wire [2:0] min_last = min_div_field == 3'h0 ? 3'h0 : min_div_field - 3'h1;
  wire [7:0] min_mask = min_cnt_ff == 3'h0 ? chan_enable : (chan_enable & 8'h01);

  always_comb begin
    nxt_state = state_ff;
    if (!auto_en) begin
      nxt_state = power_mode_pkg::FULL_RATE_SCAN_STATE;
    end else if (any_event) begin
      nxt_state = power_mode_pkg::FULL_RATE_SCAN_STATE;
    end else if (quiet_done) begin
      case (state_ff)
        power_mode_pkg::FULL_RATE_SCAN_STATE: begin
          nxt_state = power_mode_pkg::REDUCED_RATE_SCAN_STATE;
        end
        power_mode_pkg::REDUCED_RATE_SCAN_STATE: begin
          if (min_en) begin
            nxt_state = power_mode_pkg::MINIMAL_SCAN_STATE;
          end
        end
        default: nxt_state = state_ff;
      endcase
    end
  end

  wire mode_change = nxt_state != state_ff;
  wire wake = mode_change && nxt_state == power_mode_pkg::FULL_RATE_SCAN_STATE;

  always_comb begin
    nxt_conv.start = 1'b0;
    nxt_conv.mask = 8'h00;
    if (wake) begin
      nxt_conv.start = 1'b1;
      nxt_conv.mask = chan_enable;
    end else if (!mode_change && rate_due) begin
      nxt_conv.start = 1'b1;
      case (state_ff)
        power_mode_pkg::MINIMAL_SCAN_STATE: nxt_conv.mask = min_mask;
        default: nxt_conv.mask = chan_enable;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gen_settings_ff <= power_mode_pkg::GEN_SETTINGS_RST;
      report_rates_ff <= power_mode_pkg::REPORT_RATES_RST;
      mode_timer_ff <= power_mode_pkg::MODE_TIMER_RST;
      reg_rdata_ff <= 16'h0000;
    end else begin
      if (wr_gen) gen_settings_ff <= reg_wdata;
      if (wr_rate) report_rates_ff <= reg_wdata;
      if (wr_timer) mode_timer_ff <= reg_wdata;
      reg_rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= power_mode_pkg::FULL_RATE_SCAN_STATE;
      conv_ff <= '0;
      tick_cnt_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      conv_ff <= nxt_conv;
      tick_cnt_ff <= ms_tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
    end
  end

  // Quiet timer saturates so a long idle does not wrap back below the limit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      quiet_cnt_ff <= 17'h0_0000;
    end else if (any_event || mode_change) begin
      quiet_cnt_ff <= 17'h0_0000;
    end else if (ms_tick && quiet_cnt_ff != 17'h1_FFFF) begin
      quiet_cnt_ff <= quiet_cnt_ff + 17'h0_0001;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rate_cnt_ff <= 8'h00;
      min_cnt_ff <= 3'h0;
    end else if (mode_change) begin
      rate_cnt_ff <= 8'h00;
      min_cnt_ff <= 3'h0;
    end else if (rate_due) begin
      rate_cnt_ff <= 8'h00;
      if (state_ff == power_mode_pkg::MINIMAL_SCAN_STATE) begin
        min_cnt_ff <= min_cnt_ff >= min_last ? 3'h0 : min_cnt_ff + 3'h1;
      end
    end else if (ms_tick) begin
      rate_cnt_ff <= rate_cnt_ff + 8'h01;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign conv_req = conv_ff;
  assign scan_mode = state_ff;

  chk_start_full_auto: assert property (@(posedge clock)
    $rose(resetn) |-> state_ff == power_mode_pkg::FULL_RATE_SCAN_STATE && auto_en)
    else $error("not full rate with auto on after reset");
  chk_full_to_reduced: assert property (@(posedge clock) disable iff (!resetn)
    state_ff == power_mode_pkg::FULL_RATE_SCAN_STATE && auto_en && quiet_done
      && !any_event |=> state_ff == power_mode_pkg::REDUCED_RATE_SCAN_STATE)
    else $error("full rate did not step down after quiet period");
  chk_reduced_to_min: assert property (@(posedge clock) disable iff (!resetn)
    state_ff == power_mode_pkg::REDUCED_RATE_SCAN_STATE && auto_en && quiet_done
      && !any_event |=> state_ff == (min_en ? power_mode_pkg::MINIMAL_SCAN_STATE
      : power_mode_pkg::REDUCED_RATE_SCAN_STATE))
    else $error("reduced rate step wrong");
  chk_quiet_units: assert property (@(posedge clock) disable iff (!resetn)
    state_ff != power_mode_pkg::FULL_RATE_SCAN_STATE && $changed(state_ff) && !$past(any_event)
      && $past(auto_en) |-> $past(quiet_cnt_ff) >= {$past(timer_field), 9'h000})
    else $error("step down before quiet period");
  chk_event_wake: assert property (@(posedge clock) disable iff (!resetn)
    any_event && auto_en && state_ff != power_mode_pkg::FULL_RATE_SCAN_STATE |=>
      state_ff == power_mode_pkg::FULL_RATE_SCAN_STATE && conv_ff.start
      && conv_ff.mask == $past(chan_enable))
    else $error("event did not wake to full rate");
  chk_timer_restart: assert property (@(posedge clock) disable iff (!resetn)
    any_event |=> quiet_cnt_ff == 17'h0_0000)
    else $error("quiet timer not restarted");
  chk_auto_off: assert property (@(posedge clock) disable iff (!resetn)
    !auto_en |=> state_ff == power_mode_pkg::FULL_RATE_SCAN_STATE)
    else $error("mode moved with auto switching off");
  chk_min_mask: assert property (@(posedge clock) disable iff (!resetn)
    conv_ff.start && $past(state_ff) == power_mode_pkg::MINIMAL_SCAN_STATE
      && $past(state_ff) == state_ff && $past(min_cnt_ff) != 3'h0
      |-> conv_ff.mask == ($past(chan_enable) & 8'h01))
    else $error("minimal state converted extra channels");
  chk_full_mask: assert property (@(posedge clock) disable iff (!resetn)
    conv_ff.start && $past(state_ff) != power_mode_pkg::MINIMAL_SCAN_STATE
      |-> conv_ff.mask == $past(chan_enable))
    else $error("full or reduced conversion mask wrong");
  chk_reduced_mask: assert property (@(posedge clock) disable iff (!resetn)
    conv_ff.start && $past(state_ff) == power_mode_pkg::REDUCED_RATE_SCAN_STATE
      |-> conv_ff.mask == $past(chan_enable))
    else $error("reduced rate conversion mask wrong");
  chk_min_full_cycle: assert property (@(posedge clock) disable iff (!resetn)
    conv_ff.start && $past(state_ff) == power_mode_pkg::MINIMAL_SCAN_STATE
      && $past(state_ff) == state_ff && $past(min_cnt_ff) == 3'h0
      |-> conv_ff.mask == $past(chan_enable))
    else $error("minimal state skipped full conversion");
endmodule

// ### hw/power_mode_pkg.sv
// Constants and types shared by the power mode scheduler
package power_mode_pkg;
  localparam logic [7:0] GEN_SETTINGS_OFS = 8'h80;
  localparam logic [7:0] REPORT_RATES_OFS = 8'h83;
  localparam logic [7:0] MODE_TIMER_OFS = 8'h84;
  localparam int AUTO_EN_BIT = 5;
  localparam int MIN_EN_BIT = 4;
  localparam int MIN_DIV_LSB = 0;
  localparam int MIN_DIV_W = 3;
  localparam int MODE_RD_LSB = 8;
  localparam int TIMER_FIELD_LSB = 8;
  localparam logic [15:0] GEN_SETTINGS_RST = 16'h0020;
  localparam logic [15:0] REPORT_RATES_RST = 16'h4010;
  localparam logic [15:0] MODE_TIMER_RST = 16'h0A00;
  localparam int CLOCK_MHZ = 100;
  localparam int MS_TICK_NS = 1000000;
  localparam int MS_TICK_CYCLES = MS_TICK_NS * CLOCK_MHZ / 1000;
  localparam int TIMER_UNIT_MS = 512;

  typedef enum logic [1:0] {
    FULL_RATE_SCAN_STATE,
    REDUCED_RATE_SCAN_STATE,
    MINIMAL_SCAN_STATE
  } scan_state_t;

  typedef struct packed {
    logic start;
    logic [7:0] mask;
  } conv_req_t;
endpackage

// ### tb/sense_engine_model.sv
// Behavioural channel sensing engine: raises events on command, times conversion starts
`timescale 1ns/100ps
module sense_engine_model (
  input wire logic clock,
  input wire logic resetn,
  input wire power_mode_pkg::conv_req_t conv_req,
  input wire logic [7:0] chan_enable,
  input wire logic [7:0] fire,
  output logic [7:0] chan_event,
  output int gap
);
  int since;
  // A disabled channel never reports, as on the real detectors
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chan_event <= 8'h00;
      since <= 0;
      gap <= 0;
    end else begin
      chan_event <= fire & chan_enable;
      since <= conv_req.start ? 1 : since + 1;
      if (conv_req.start) begin
        gap <= since;
      end
    end
  end
endmodule

// ### tb/test_auto_power_mode_scheduler.sv
// Self-checking bench for the power mode scheduler
`timescale 1ns/100ps
module test_auto_power_mode_scheduler;
  localparam int MSC = 10;
  logic clock, resetn, reg_wr;
  logic [7:0] reg_addr, chan_enable, fire, chan_event;
  logic [15:0] reg_wdata, reg_rdata;
  power_mode_pkg::conv_req_t conv_req;
  logic [1:0] scan_mode;
  int gap, errors, cmp_count, seed, nf;
  auto_power_mode_scheduler #(.MS_CYCLES(MSC), .CHANNELS(8)) dut_u (.clock(clock),
    .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .chan_enable(chan_enable), .chan_event(chan_event),
    .conv_req(conv_req), .scan_mode(scan_mode));
  sense_engine_model model_u (.clock(clock), .resetn(resetn), .conv_req(conv_req),
    .chan_enable(chan_enable), .fire(fire), .chan_event(chan_event), .gap(gap));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [15:0] exp_mask(input logic [7:0] en, input logic full);
    return {8'h00, full ? en : (en & 8'h01)};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(posedge clock); #1 reg_wr = 1'b0;
    @(posedge clock); #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr = a;
    @(posedge clock); #1 check(reg_rdata, exp, "register read");
  endtask
  task automatic wait_ms(input int ms);
    repeat (ms * MSC) @(posedge clock);
    #1;
  endtask
  task automatic next_start();
    int n;
    n = 0;
    do begin
      @(posedge clock); #1 n++;
    end while (conv_req.start !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      errors++;
      $display("Error at %0t: no conversion start", $time);
    end
  endtask
  task automatic pulse_event();
    fire = (8'($random(seed)) & chan_enable) | 8'h01;
    @(posedge clock); #1 fire = 8'h00;
  endtask
  task automatic finish_test();
    $display("Checks made %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    // Runs near 2600 ms of scaled time; the limit leaves wide room
    #(60000 * 10);
    errors++;
    finish_test();
  end
  initial begin
    seed = 84;
    resetn = 1'b0; reg_wr = 1'b0; reg_addr = 8'h00; reg_wdata = 16'h0000; fire = 8'h00;
    chan_enable = 8'($random(seed)) | 8'h03;
    repeat (12) @(posedge clock);
    #1 resetn = 1'b1;
    rd(power_mode_pkg::GEN_SETTINGS_OFS, power_mode_pkg::GEN_SETTINGS_RST);
    rd(power_mode_pkg::REPORT_RATES_OFS, power_mode_pkg::REPORT_RATES_RST);
    rd(power_mode_pkg::MODE_TIMER_OFS, power_mode_pkg::MODE_TIMER_RST);
    rd(8'h42, 16'h0000);
    $display("Test reset values done");
    wr(power_mode_pkg::REPORT_RATES_OFS, 16'h0201);
    wr(power_mode_pkg::MODE_TIMER_OFS, 16'h0100);
    wr(power_mode_pkg::GEN_SETTINGS_OFS, 16'h0034);
    next_start();
    next_start();
    check({8'h00, conv_req.mask}, exp_mask(chan_enable, 1'b1), "full mask");
    @(posedge clock); #1;
    check(16'(gap), 16'(MSC), "full interval");
    wait_ms(400);
    pulse_event();
    wait_ms(500);
    check(16'(scan_mode), 16'h0000, "quiet timer restart on event");
    wait_ms(20);
    check(16'(scan_mode), 16'h0001, "step to reduced");
    next_start();
    next_start();
    @(posedge clock); #1;
    check(16'(gap), 16'(2 * MSC), "reduced interval");
    wait_ms(460);
    check(16'(scan_mode), 16'h0001, "quiet timer restart on step");
    wait_ms(60);
    check(16'(scan_mode), 16'h0002, "step to minimal");
    rd(power_mode_pkg::GEN_SETTINGS_OFS, 16'h0234);
    $display("Test step down done");
    nf = 0;
    for (int i = 0; i < 8; i++) begin
      next_start();
      if ({8'h00, conv_req.mask} === exp_mask(chan_enable, 1'b1)) nf++;
      else check({8'h00, conv_req.mask}, exp_mask(chan_enable, 1'b0), "minimal mask");
    end
    check(16'(nf), 16'h0002, "full scans in eight minimal cycles");
    pulse_event();
    @(posedge clock); #1;
    check({14'h0000, scan_mode}, 16'h0000, "wake mode");
    check({7'h00, conv_req}, {7'h00, 1'b1, chan_enable}, "wake scan");
    $display("Test wake done");
    wr(power_mode_pkg::GEN_SETTINGS_OFS, 16'h0014);
    wait_ms(1100);
    check(16'(scan_mode), 16'h0000, "auto switching off");
    $display("Test auto off done");
    finish_test();
  end
endmodule
